// File: core/timer_counter_compare_regs.v
// Behaviour
// - output channel 0 drives its active level only while its enable bit is set
// - input channel 0 captures only while its enable bit is set
// - count register shows the running count; a write replaces it
// - counting clock is kernel clock divided by divider plus one
// - a written divider takes effect at the next update event
// - a writable 16-bit reload value sets the counting period
// - repetition counter reloads from repeat value; update event on an overflow while it is zero
// - with the shadow bit set, shadow registers load only on update events paced by repetition
// - input channel value holds last captured count, read-only to software
// - output channel compare value; active copy reloads on update if shadowed
//
// Design decision made here: the AHB-Lite slave port.
`include "timer_counter_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module timer_counter_compare_regs #(
    parameter CW = 16,                       // counter width
    parameter RW = 8                         // repetition width
) (
    input  wire        clk_sys,              // timer kernel clock
    input  wire        reset,                // synchronous reset, active high
    input  wire        hsel,                 // slave select
    input  wire [31:0] haddr,                // byte address
    input  wire [1:0]  htrans,               // transfer type
    input  wire        hwrite,               // write when high
    input  wire [2:0]  hsize,                // transfer size
    input  wire        hready,               // bus ready in
    input  wire [31:0] hwdata,               // write data
    output reg  [31:0] hrdata,               // read data
    output wire        hreadyout,            // always ready
    output wire        hresp,                // always OKAY
    input  wire        chan0Pin,             // channel 0 capture input pin
    input  wire        chan1Pin,             // channel 1 capture input pin
    output reg         chan0_output,         // channel 0 compare output
    output reg         chan1Output,          // channel 1 compare output
    output reg         updateEvent,          // one-cycle update event
    output wire        irq                   // level interrupt
);

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    reg [`CTL_WIDTH-1:0] control;
    reg [CW-1:0]         count_field;
    reg [CW-1:0]         divider_field;
    reg [CW-1:0]         divActive;
    reg [CW-1:0]         reload_field;
    reg [CW-1:0]         reloadActive;
    reg [RW-1:0]         repeat_field;
    reg [RW-1:0]         repeatCount;
    reg [CW-1:0]         chan0_value_field;
    reg [CW-1:0]         chan1_value_field;
    reg [CW-1:0]         match0Active;
    reg [CW-1:0]         match1Active;
    reg [`IRQ_WIDTH-1:0] irqStatus;
    reg [`IRQ_WIDTH-1:0] irqEnable;
    reg                  phaseWrite;
    reg [7:0]            phaseAddr;

    wire run        = control[`CTL_RUN_BIT];
    wire chan0_enable = control[`CTL_EN0_BIT];
    wire chan1Enable = control[`CTL_EN1_BIT];
    wire chan0Input = control[`CTL_IN0_BIT];
    wire chan1Input = control[`CTL_IN1_BIT];
    wire shadowOn   = control[`CTL_SHADOW_BIT];

    // ----------------------------------------------------------------------
    // bus address phase
    // ----------------------------------------------------------------------
    // single-cycle slave: never stalls, always OKAY; sizes other than word are
    // still treated as word writes since software must use whole words
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    wire   accept    = hsel & hready & htrans[1];

    always @(posedge clk_sys) begin
        if (reset) begin
            phaseWrite <= 1'b0;
            phaseAddr  <= 8'h00;
        end else begin
            phaseWrite <= accept & hwrite;
            phaseAddr  <= haddr[7:0];
        end
    end

    wire wrCount   = phaseWrite && phaseAddr == `OFS_COUNT;
    wire wrDivider = phaseWrite && phaseAddr == `OFS_DIVIDER;
    wire wrReload  = phaseWrite && phaseAddr == `OFS_RELOAD;
    wire wrRepeat  = phaseWrite && phaseAddr == `OFS_REPEAT;
    wire wrChan0   = phaseWrite && phaseAddr == `OFS_CHAN0;
    wire wrChan1   = phaseWrite && phaseAddr == `OFS_CHAN1;
    wire wrControl = phaseWrite && phaseAddr == `OFS_CONTROL;
    wire wrEnable  = phaseWrite && phaseAddr == `OFS_IRQ_ENABLE;
    wire wrClear   = phaseWrite && phaseAddr == `OFS_IRQ_CLEAR;

    // ----------------------------------------------------------------------
    // prescaler and capture inputs
    // ----------------------------------------------------------------------
    wire tick;
    wire capt0Edge;
    wire capt1Edge;

    clock_prescaler #(
        .WIDTH     (CW)
    ) divider (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .run       (run),
        .divActive (divActive),
        .restart   (next_update),
        .tick      (tick)
    );

    pulse_sync sync0 (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pinIn     (chan0Pin),
        .risePulse (capt0Edge)
    );

    pulse_sync sync1 (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pinIn     (chan1Pin),
        .risePulse (capt1Edge)
    );

    // ----------------------------------------------------------------------
    // counter and repetition
    // ----------------------------------------------------------------------
    wire overflow = tick && (count_field == reloadActive);
    wire repZero  = (repeatCount == {RW{1'b0}});
    wire next_update = overflow && repZero;

    // a software count write wins over counting in the same cycle
    always @(posedge clk_sys) begin
        if (reset) begin
            count_field <= `RST_VALUE16;
        end else if (wrCount) begin
            count_field <= hwdata[CW-1:0];
        end else if (overflow) begin
            count_field <= `RST_VALUE16;
        end else if (tick) begin
            count_field <= count_field + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // repetition counter reloads at each update, else counts overflows down
    always @(posedge clk_sys) begin
        if (reset) begin
            repeatCount <= `RST_REPEAT8;
            updateEvent <= 1'b0;
        end else begin
            updateEvent <= next_update;
            if (next_update) begin
                repeatCount <= repeat_field;
            end else if (overflow) begin
                repeatCount <= repeatCount - {{(RW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------------
    // preload registers and shadows
    // ----------------------------------------------------------------------
    // with the shadow bit set, shadows copy only on update events, so the repeat value paces them
    always @(posedge clk_sys) begin
        if (reset) begin
            control       <= `RST_CONTROL;
            divider_field <= `RST_VALUE16;
            reload_field  <= `RST_VALUE16;
            repeat_field  <= `RST_REPEAT8;
            divActive     <= `RST_VALUE16;
            reloadActive  <= `RST_VALUE16;
            irqEnable     <= `RST_IRQ;
        end else begin
            if (wrControl) control <= hwdata[`CTL_WIDTH-1:0];
            if (wrDivider) divider_field <= hwdata[CW-1:0];
            if (wrReload) reload_field <= hwdata[CW-1:0];
            if (wrRepeat) repeat_field <= hwdata[RW-1:0];
            if (wrEnable) irqEnable <= hwdata[`IRQ_WIDTH-1:0];
            // load at the wrapping edge so the new division starts at phase zero
            if (next_update) begin
                divActive <= divider_field;
            end
            // reload without shadowing acts at once
            if (updateEvent || !shadowOn) begin
                reloadActive <= reload_field;
            end
        end
    end

    // ----------------------------------------------------------------------
    // channels: compare value or capture latch
    // ----------------------------------------------------------------------
    wire capt0 = chan0Input && chan0_enable && capt0Edge;
    wire capt1 = chan1Input && chan1Enable && capt1Edge;
    wire hit0  = !chan0Input && run && count_field == match0Active;
    wire hit1  = !chan1Input && run && count_field == match1Active;

    // input mode ignores software writes: value is read-only there
    always @(posedge clk_sys) begin
        if (reset) begin
            chan0_value_field <= `RST_VALUE16;
            chan1_value_field <= `RST_VALUE16;
            match0Active      <= `RST_VALUE16;
            match1Active      <= `RST_VALUE16;
        end else begin
            if (capt0) begin
                chan0_value_field <= count_field;
            end else if (wrChan0 && !chan0Input) begin
                chan0_value_field <= hwdata[CW-1:0];
            end
            if (capt1) begin
                chan1_value_field <= count_field;
            end else if (wrChan1 && !chan1Input) begin
                chan1_value_field <= hwdata[CW-1:0];
            end
            if (updateEvent || !shadowOn) begin
                match0Active <= chan0_value_field;
                match1Active <= chan1_value_field;
            end
        end
    end

    // output is high from a match until the count wraps; disabled is low
    always @(posedge clk_sys) begin
        if (reset) begin
            chan0_output <= 1'b0;
            chan1Output  <= 1'b0;
        end else begin
            if (!chan0_enable || chan0Input || overflow) begin
                chan0_output <= 1'b0;
            end else if (hit0) begin
                chan0_output <= 1'b1;
            end
            if (!chan1Enable || chan1Input || overflow) begin
                chan1Output <= 1'b0;
            end else if (hit1) begin
                chan1Output <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------------
    wire [`IRQ_WIDTH-1:0] events = {capt1, capt0, hit1 & tick, hit0 & tick, next_update};
    wire [`IRQ_WIDTH-1:0] clearMask = wrClear ? hwdata[`IRQ_WIDTH-1:0] : `RST_IRQ;

    // a new event wins over a clear in the same cycle
    always @(posedge clk_sys) begin
        if (reset) begin
            irqStatus <= `RST_IRQ;
        end else begin
            irqStatus <= (irqStatus & ~clearMask) | events;
        end
    end

    assign irq = |(irqStatus & irqEnable);

    // ----------------------------------------------------------------------
    // read data, registered in the data phase
    // ----------------------------------------------------------------------
    // reserved upper bits read zero; unmapped addresses read zero
    always @(posedge clk_sys) begin
        if (reset) begin
            hrdata <= 32'h00000000;
        end else if (accept && !hwrite) begin
            case (haddr[7:0])
                `OFS_CONTROL:    hrdata <= {26'h0000000, control};
                `OFS_COUNT:      hrdata <= {16'h0000, count_field};
                `OFS_DIVIDER:    hrdata <= {16'h0000, divider_field};
                `OFS_RELOAD:     hrdata <= {16'h0000, reload_field};
                `OFS_REPEAT:     hrdata <= {24'h000000, repeat_field};
                `OFS_CHAN0:      hrdata <= {16'h0000, chan0_value_field};
                `OFS_CHAN1:      hrdata <= {16'h0000, chan1_value_field};
                `OFS_IRQ_STATUS: hrdata <= {27'h0000000, irqStatus};
                `OFS_IRQ_ENABLE: hrdata <= {27'h0000000, irqEnable};
                default:         hrdata <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire

// File: core/timer_counter_consts.vh
`ifndef TIMER_COUNTER_CONSTS_VH
`define TIMER_COUNTER_CONSTS_VH

// -----------------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------------
`define OFS_CONTROL      8'h20
`define OFS_COUNT        8'h24
`define OFS_DIVIDER      8'h28
`define OFS_RELOAD       8'h2C
`define OFS_REPEAT       8'h30
`define OFS_CHAN0        8'h34
`define OFS_CHAN1        8'h38
`define OFS_IRQ_STATUS   8'h48
`define OFS_IRQ_ENABLE   8'h4C
`define OFS_IRQ_CLEAR    8'h50

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define CTL_RUN_BIT      0
`define CTL_EN0_BIT      1
`define CTL_EN1_BIT      2
`define CTL_IN0_BIT      3
`define CTL_IN1_BIT      4
`define CTL_SHADOW_BIT   5
`define CTL_WIDTH        6
`define IRQ_UPDATE_BIT   0
`define IRQ_MATCH0_BIT   1
`define IRQ_MATCH1_BIT   2
`define IRQ_CAPT0_BIT    3
`define IRQ_CAPT1_BIT    4
`define IRQ_WIDTH        5

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define RST_CONTROL      6'h00
`define RST_VALUE16      16'h0000
`define RST_REPEAT8      8'h00
`define RST_IRQ          5'h00

`endif

// File: core/pulse_sync.v
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser followed by a rising edge detector
module pulse_sync (
    input  wire clk_sys,  // system clock
    input  wire reset,    // synchronous reset, active high
    input  wire pinIn,    // asynchronous pin
    output reg  risePulse // one cycle on a rising edge
);

    reg stageA;
    reg stageB;
    reg stageC;

    // ----------------------------------------------------------------------
    // synchroniser
    // ----------------------------------------------------------------------
    // stageA is read only by stageB, so metastability stays contained
    always @(posedge clk_sys) begin
        if (reset) begin
            stageA    <= 1'b0;
            stageB    <= 1'b0;
            stageC    <= 1'b0;
            risePulse <= 1'b0;
        end else begin
            stageA    <= pinIn;
            stageB    <= stageA;
            stageC    <= stageB;
            risePulse <= stageB & ~stageC;
        end
    end

endmodule

`default_nettype wire

// File: core/clock_prescaler.v
`timescale 1ns/1ps
`default_nettype none

// divides the kernel clock into one-cycle counting ticks
module clock_prescaler #(
    parameter WIDTH = 16
) (
    input  wire             clk_sys,     // kernel clock
    input  wire             reset,       // synchronous reset, active high
    input  wire             run,         // counting enabled
    input  wire [WIDTH-1:0] divActive,   // shadow divider value
    input  wire             restart,     // restart the division
    output wire             tick         // counting clock enable pulse
);

    reg [WIDTH-1:0] phase;

    // divide by divActive+1; zero gives a tick every cycle
    assign tick = run & (phase == divActive);

    // ----------------------------------------------------------------------
    // phase counter
    // ----------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset || restart || !run) begin
            phase <= {WIDTH{1'b0}};
        end else if (tick) begin
            phase <= {WIDTH{1'b0}};
        end else begin
            phase <= phase + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// File: test/timer_counter_props.sv
`include "timer_counter_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module timer_counter_props #(
    parameter CW = 16, // counter width
    parameter RW = 8   // repeat width
) (
    input wire logic        clk_sys,      // clock
    input wire logic        reset,        // sync reset
    input wire logic        hsel,         // select
    input wire logic [31:0] haddr,        // address
    input wire logic [1:0]  htrans,       // transfer
    input wire logic        hwrite,       // write
    input wire logic        hready,       // ready in
    input wire logic [31:0] hwdata,       // wdata
    input wire logic [31:0] hrdata,       // rdata
    input wire logic        hreadyout,    // ready out
    input wire logic        hresp,        // response
    input wire logic        chan0_output, // ch0 out
    input wire logic        chan1Output,  // ch1 out
    input wire logic        updateEvent,  // update
    input wire logic        irq           // interrupt
);
    // --------------------------------
    // control and enable rebuilt from bus writes
    // --------------------------------
    logic       wrPend;
    logic [7:0] wrAddr;
    logic [5:0] ctl;
    logic [4:0] irqEn;

    // data phase trails the accepted address phase by one cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            ctl <= `RST_CONTROL;
            irqEn <= `RST_IRQ;
        end else begin
            wrPend <= hsel && hready && htrans[1] && hwrite;
            wrAddr <= haddr[7:0];
            if (wrPend && wrAddr == `OFS_CONTROL) begin
                ctl <= hwdata[5:0];
            end
            if (wrPend && wrAddr == `OFS_IRQ_ENABLE) begin
                irqEn <= hwdata[4:0];
            end
        end
    end

    // --------------------------------
    // properties
    // --------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence rdReq;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence rd16;
        rdReq ##0 (haddr[7:0] inside {`OFS_COUNT, `OFS_DIVIDER, `OFS_RELOAD, `OFS_CHAN0, `OFS_CHAN1});
    endsequence
    sequence rd8;
        rdReq ##0 (haddr[7:0] == `OFS_REPEAT);
    endsequence
    sequence rdHole;
        rdReq ##0 (haddr[7:0] == 8'h60);
    endsequence

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=> !updateEvent && !chan0_output && !irq && hrdata == 32'h0)
        else $error("outputs active after reset");
    AST_UNMAPPED_ZERO: assert property (rdHole |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_UPPER16_ZERO: assert property (rd16 |=> hrdata[31:16] == 16'h0)
        else $error("upper half of value read not zero");
    AST_UPPER8_ZERO: assert property (rd8 |=> hrdata[31:8] == 24'h0)
        else $error("upper bits of repeat read not zero");
    AST_IRQ_MASKED: assert property (irqEn == 5'h00 |-> !irq)
        else $error("interrupt with all sources masked");
    AST_CH0_OFF: assert property (!ctl[`CTL_EN0_BIT] [*2] |=> !chan0_output)
        else $error("channel 0 output active while disabled");
    AST_CH1_OFF: assert property (!ctl[`CTL_EN1_BIT] [*2] |=> !chan1Output)
        else $error("channel 1 output active while disabled");
    AST_NO_UPDATE_STOPPED: assert property (!ctl[`CTL_RUN_BIT] [*3] |-> !updateEvent)
        else $error("update event while counter stopped");
endmodule

bind timer_counter_compare_regs timer_counter_props #(.CW(CW), .RW(RW)) chk (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chan0_output(chan0_output),
    .chan1Output(chan1Output), .updateEvent(updateEvent), .irq(irq)
);

`default_nettype wire

// File: test/tb_timer_counter_compare_regs.sv
`include "timer_counter_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module tb_timer_counter_compare_regs;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        chan0Pin = 1'b0;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         chan0_output;
    wire         chan1Output;
    wire         updateEvent;
    wire         irq;
    logic [31:0] rd;
    int          badCount = 0;
    int          checks = 0;
    int          sinceUpd = 0;
    int          lastGap = 0;
    int          r, d, p, c, x;
    logic [7:0]  regs [10] = '{`OFS_COUNT, `OFS_DIVIDER, `OFS_RELOAD, `OFS_REPEAT, `OFS_CHAN0,
                              `OFS_CHAN1, `OFS_CONTROL, `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE, 8'h60};

    always #50 clk_sys = ~clk_sys;

    // one slave, so its ready is the bus ready
    timer_counter_compare_regs uut (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .chan0Pin(chan0Pin), .chan1Pin(1'b0),
        .chan0_output(chan0_output), .chan1Output(chan1Output), .updateEvent(updateEvent),
        .irq(irq)
    );

    // cycles between the last two update events
    always @(posedge clk_sys) begin
        if (updateEvent === 1'b1) begin
            lastGap <= sinceUpd;
            sinceUpd <= 1;
        end else begin
            sinceUpd <= sinceUpd + 1;
        end
    end

    // --------------------------------
    // bus, compare and expectation helpers
    // --------------------------------
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // settle past the write edge before looking at the level
    task automatic chk_irq(input logic exp);
        @(negedge clk_sys);
        cmp_bit(irq, exp);
    endtask

    task automatic wait_upd;
        do @(posedge clk_sys); while (updateEvent !== 1'b1);
        @(negedge clk_sys);
    endtask

    task automatic pulse_pin;
        @(posedge clk_sys);
        chan0Pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chan0Pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    function automatic int period(int rl, int dv, int rp);
        return (rl + 1) * (dv + 1) * (rp + 1);
    endfunction

    function automatic logic [31:0] fieldMask(logic [7:0] a);
        return (a == `OFS_REPEAT) ? 32'h000000FF : 32'h0000FFFF;
    endfunction

    task automatic close_out;
        $display("checks=%0d badCount=%0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang is cut short well past the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        close_out;
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        x = $urandom(66010);
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        // every register but the clear, and a hole, reads zero after reset
        foreach (regs[i]) begin
            bus(regs[i], 1'b0, 32'h0);
            cmp_word(rd, 32'h0);
        end
        // random values round trip while stopped
        repeat (3) begin
            for (int i = 0; i < 6; i++) begin
                x = $urandom & fieldMask(regs[i]);
                bus(regs[i], 1'b1, x);
                bus(regs[i], 1'b0, 32'h0);
                cmp_word(rd, x);
            end
        end
        // update spacing; a new divider waits for the next update
        r = 6 + $urandom % 4;
        d = $urandom % 3;
        p = $urandom % 3;
        bus(`OFS_RELOAD, 1'b1, r);
        bus(`OFS_REPEAT, 1'b1, p);
        bus(`OFS_DIVIDER, 1'b1, d);
        bus(`OFS_COUNT, 1'b1, 32'h0);
        bus(`OFS_CONTROL, 1'b1, 32'h1);
        repeat (3) wait_upd;
        cmp_word(lastGap, period(r, d, p));
        x = d;
        d = (x + 1 + $urandom % 2) % 3;
        bus(`OFS_DIVIDER, 1'b1, d);
        wait_upd;
        cmp_word(lastGap, period(r, x, p));
        wait_upd;
        cmp_word(lastGap, period(r, d, p));
        // compare match drives the output only while enabled
        c = 8 + $urandom % 30;
        bus(`OFS_DIVIDER, 1'b1, 32'h7);
        bus(`OFS_RELOAD, 1'b1, 32'h28);
        bus(`OFS_CHAN0, 1'b1, c);
        bus(`OFS_CONTROL, 1'b1, 32'h3);
        wait_upd;
        do @(posedge clk_sys); while (chan0_output !== 1'b1);
        bus(`OFS_COUNT, 1'b0, 32'h0);
        cmp_word(rd, c);
        bus(`OFS_CONTROL, 1'b1, 32'h1);
        repeat (2) @(posedge clk_sys);
        repeat (400) begin
            @(posedge clk_sys);
            cmp_bit(chan0_output, 1'b0);
        end
        // capture, read-only value, interrupt mask and clear
        bus(`OFS_CONTROL, 1'b1, 32'hA);
        bus(`OFS_IRQ_CLEAR, 1'b1, 32'h1F);
        bus(`OFS_IRQ_ENABLE, 1'b1, 32'h8);
        x = $urandom & 32'hFFFF;
        bus(`OFS_COUNT, 1'b1, x);
        pulse_pin;
        chk_irq(1'b1);
        bus(`OFS_IRQ_STATUS, 1'b0, 32'h0);
        cmp_word(rd, 32'h8);
        bus(`OFS_CHAN0, 1'b1, ~x & 32'hFFFF);
        bus(`OFS_CHAN0, 1'b0, 32'h0);
        cmp_word(rd, x);
        bus(`OFS_IRQ_ENABLE, 1'b1, 32'h0);
        chk_irq(1'b0);
        bus(`OFS_IRQ_ENABLE, 1'b1, 32'h8);
        chk_irq(1'b1);
        bus(`OFS_IRQ_CLEAR, 1'b1, 32'h8);
        chk_irq(1'b0);
        bus(`OFS_CONTROL, 1'b1, 32'h8);
        bus(`OFS_COUNT, 1'b1, ~x & 32'hFFFF);
        pulse_pin;
        bus(`OFS_CHAN0, 1'b0, 32'h0);
        cmp_word(rd, x);
        bus(`OFS_IRQ_STATUS, 1'b0, 32'h0);
        cmp_word(rd, 32'h0);
        close_out;
    end
endmodule

`default_nettype wire
